// ===== logic/etc_timer.v
// Purpose: Three-channel eight-bit timer/event counter with AXI4-Lite registers
// Assumes: MCLK 50 MHz, RST asynchronous active high, event pins asynchronous
// Notes:   Each channel: counter, compare, clock select, mode control, wave out

`timescale 1ns/10ps
`include "etc_timer_map.vh"

// ==========================================================
// One timer channel
module etc_channel (
   input  wire       clk,
   input  wire       rst,
   input  wire [11:0] presc,
   input  wire       ev_pin,
   input  wire       cmp_we,
   input  wire [7:0] cmp_wdata,
   input  wire       clk_we,
   input  wire [2:0] clk_wdata,
   input  wire       mode_we,
   input  wire [7:0] mode_wdata,
   output reg  [7:0] count_q,
   output reg  [7:0] compare_q,
   output reg  [2:0] clksel_q,
   output wire [7:0] mode_rd,
   output reg        irq_q,
   output wire       wave_o,
   output wire       wave_oe
);
   reg  [7:0]  mode_q;
   reg         ev_s1_q;
   reg         ev_s2_q;
   reg         ev_s3_q;
   reg         ff_q;
   reg  [11:0] presc_base_q;
   wire        cnt_en   = mode_q[`ETC_MODE_CNT_EN];
   wire        pwm_mode = mode_q[`ETC_MODE_PWM];
   wire        tog_pol  = mode_q[`ETC_MODE_TOG_POL];
   wire        ev_rise  = ev_s2_q & ~ev_s3_q;
   wire        ev_fall  = ~ev_s2_q & ev_s3_q;
   wire [11:0] rel      = presc - presc_base_q;
   reg         tick;
   wire        match    = cnt_en & tick & (count_q == compare_q);
   wire        ovf      = cnt_en & tick & (count_q == 8'hFF);

   // Set and reset controls read as zero after a write
   assign mode_rd = {mode_q[7:4], 2'b00, mode_q[1:0]};
   assign wave_oe = mode_q[`ETC_MODE_OUT_EN];
   // PWM drives level ff_q xor polarity; ff_q is "active" flag in PWM
   assign wave_o  = wave_oe & (pwm_mode ? (ff_q ^ tog_pol) : ff_q);

   // ==========================================================
   // Count clock selection
   always @* begin
      case (clksel_q)
         3'h0: tick = ev_fall;
         3'h1: tick = ev_rise;
         3'h2: tick = 1'b1;
         3'h3: tick = (rel[1:0] == 2'h3);
         3'h4: tick = (rel[3:0] == 4'hF);
         3'h5: tick = (rel[5:0] == 6'h3F);
         3'h6: tick = (rel[7:0] == 8'hFF);
         default: tick = (rel[9:0] == 10'h3FF);
      endcase
   end

   // ==========================================================
   // Registers, counter and output flip-flop
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ev_s1_q      <= 1'b0;
         ev_s2_q      <= 1'b0;
         ev_s3_q      <= 1'b0;
         mode_q       <= `ETC_RST_BYTE;
         compare_q    <= `ETC_RST_BYTE;
         clksel_q     <= 3'h0;
         count_q      <= `ETC_RST_BYTE;
         irq_q        <= 1'b0;
         ff_q         <= 1'b0;
         presc_base_q <= 12'h000;
      end else begin
         ev_s1_q <= ev_pin;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
         irq_q   <= match;
         if (cmp_we)
            compare_q <= cmp_wdata;
         if (clk_we)
            clksel_q <= clk_wdata;
         if (mode_we) begin
            mode_q <= {mode_wdata[7:6], 2'b00, mode_wdata[3:0]};
            // Start free of prescaler phase: start error at most one tick
            if (mode_wdata[`ETC_MODE_CNT_EN] & ~cnt_en)
               presc_base_q <= presc;
         end
         if (!cnt_en) begin
            count_q <= 8'h00;
            if (pwm_mode)
               ff_q <= 1'b0;
         end else if (tick) begin
            if (!pwm_mode && match)
               count_q <= 8'h00;
            else
               count_q <= count_q + 8'h01;
         end
         if (cnt_en && pwm_mode) begin
            if (match)
               ff_q <= 1'b0;
            else if (ovf)
               ff_q <= 1'b1;
         end else if (cnt_en && match && tog_pol) begin
            ff_q <= ~ff_q;
         end
         if (mode_we && !mode_wdata[`ETC_MODE_PWM]) begin
            if (mode_wdata[`ETC_MODE_FF_SET] & ~mode_wdata[`ETC_MODE_FF_CLR])
               ff_q <= 1'b1;
            else if (~mode_wdata[`ETC_MODE_FF_SET] & mode_wdata[`ETC_MODE_FF_CLR])
               ff_q <= 1'b0;
         end else if (mode_we && mode_wdata[`ETC_MODE_PWM]
                      && !mode_wdata[`ETC_MODE_CNT_EN]) begin
            ff_q <= 1'b0;
         end
      end
   end
endmodule // etc_channel

module etc_timer (
   input  wire        MCLK,
   input  wire        RST,
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output wire        AWREADY,
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output wire        WREADY,
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output wire        ARREADY,
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   input  wire [2:0]  EVENT_IN,
   output wire [2:0]  WAVE_OUT,
   output wire [2:0]  WAVE_OE,
   output wire [2:0]  MATCH_IRQ
);
   reg  [7:0]  aw_q;
   reg         aw_ok_q;
   reg  [31:0] wd_q;
   reg  [3:0]  ws_q;
   reg         wd_ok_q;
   reg  [`ETC_PRESC_W-1:0] presc_q;
   wire [23:0] count_v;
   wire [23:0] cmp_v;
   wire [8:0]  clk_v;
   wire [23:0] mode_v;
   wire        do_wr    = aw_ok_q & wd_ok_q & ~BVALID;
   wire [1:0]  wch      = aw_q[5:4];
   wire [3:0]  wreg     = {aw_q[3:2], 2'b00};
   wire        wmapped  = (wch < 2'd3) & (aw_q[7:6] == 2'b00);
   wire [1:0]  rch      = ARADDR[5:4];
   wire [3:0]  rreg     = {ARADDR[3:2], 2'b00};
   wire        rmapped  = (rch < 2'd3) & (ARADDR[7:6] == 2'b00);

   assign AWREADY = ~aw_ok_q;
   assign WREADY  = ~wd_ok_q;
   assign ARREADY = ~RVALID;

   // ==========================================================
   // Shared free-running prescaler
   always @(posedge MCLK or posedge RST) begin
      if (RST)
         presc_q <= 12'h000;
      else
         presc_q <= presc_q + 12'h001;
   end

   // ==========================================================
   // AXI4-Lite write path
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         aw_q    <= 8'h00;
         aw_ok_q <= 1'b0;
         wd_q    <= 32'h0000_0000;
         ws_q    <= 4'h0;
         wd_ok_q <= 1'b0;
         BVALID  <= 1'b0;
         BRESP   <= `ETC_RESP_OKAY;
      end else begin
         if (AWVALID && !aw_ok_q) begin
            aw_q    <= AWADDR;
            aw_ok_q <= 1'b1;
         end
         if (WVALID && !wd_ok_q) begin
            wd_q    <= WDATA;
            ws_q    <= WSTRB;
            wd_ok_q <= 1'b1;
         end
         if (do_wr) begin
            BVALID  <= 1'b1;
            BRESP   <= wmapped ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
            aw_ok_q <= 1'b0;
            wd_ok_q <= 1'b0;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read path
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RVALID <= 1'b0;
         RDATA  <= 32'h0000_0000;
         RRESP  <= `ETC_RESP_OKAY;
      end else if (ARVALID && !RVALID) begin
         RVALID <= 1'b1;
         RRESP  <= rmapped ? `ETC_RESP_OKAY : `ETC_RESP_SLVERR;
         RDATA  <= 32'h0000_0000;
         if (rmapped) begin
            case (rreg)
               `ETC_OFF_COUNT:   RDATA <= {24'h0, count_v[rch*8 +: 8]};
               `ETC_OFF_COMPARE: RDATA <= {24'h0, cmp_v[rch*8 +: 8]};
               `ETC_OFF_CLKSEL:  RDATA <= {29'h0, clk_v[rch*3 +: 3]};
               default:          RDATA <= {24'h0, mode_v[rch*8 +: 8]};
            endcase
         end
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // ==========================================================
   // Channels
   genvar g;
   generate
      for (g = 0; g < `ETC_NUM_CH; g = g + 1) begin : ch
         wire sel = do_wr & wmapped & (wch == g) & ws_q[0];
         etc_channel u_ch (
            .clk        (MCLK),
            .rst        (RST),
            .presc      (presc_q),
            .ev_pin     (EVENT_IN[g]),
            .cmp_we     (sel & (wreg == `ETC_OFF_COMPARE)),
            .cmp_wdata  (wd_q[7:0]),
            .clk_we     (sel & (wreg == `ETC_OFF_CLKSEL)),
            .clk_wdata  (wd_q[2:0]),
            .mode_we    (sel & (wreg == `ETC_OFF_MODE)),
            .mode_wdata (wd_q[7:0]),
            .count_q    (count_v[g*8 +: 8]),
            .compare_q  (cmp_v[g*8 +: 8]),
            .clksel_q   (clk_v[g*3 +: 3]),
            .mode_rd    (mode_v[g*8 +: 8]),
            .irq_q      (MATCH_IRQ[g]),
            .wave_o     (WAVE_OUT[g]),
            .wave_oe    (WAVE_OE[g])
         );
      end
   endgenerate
endmodule // etc_timer

// ===== logic/etc_timer_map.vh
// Purpose: Register map, field positions and reset values of the timer block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   Three channels, each a block of four words
`ifndef ETC_TIMER_MAP_VH
`define ETC_TIMER_MAP_VH

// ==========================================================
// Register offsets within a channel block
`define ETC_CH_STRIDE     8'h10
`define ETC_OFF_COUNT     4'h0
`define ETC_OFF_COMPARE   4'h4
`define ETC_OFF_CLKSEL    4'h8
`define ETC_OFF_MODE      4'hC
`define ETC_NUM_CH        3

// ==========================================================
// Mode control fields
`define ETC_MODE_OUT_EN   0
`define ETC_MODE_TOG_POL  1
`define ETC_MODE_FF_CLR   2
`define ETC_MODE_FF_SET   3
`define ETC_MODE_PWM      6
`define ETC_MODE_CNT_EN   7

// ==========================================================
// Clock select codes and reset values
`define ETC_CLK_EV_FALL   3'h0
`define ETC_CLK_EV_RISE   3'h1
`define ETC_RST_BYTE      8'h00
`define ETC_PRESC_W       12

// AXI responses
`define ETC_RESP_OKAY     2'h0
`define ETC_RESP_SLVERR   2'h2

`endif

// ===== sim/etc_event_src.sv
// Purpose: External event source on one timer input pin
// Assumes: Pin is asynchronous to the bench clock
// Notes:   Gap argument gives prompt or slow pulses
`timescale 1ns/10ps
// ==========================================
// Event source
module etc_event_src (
   output reg pin
);
   initial pin = 1'b0;
   task pulse(input integer n, input integer gap);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            #(gap) pin = 1'b1;
            #53 pin = 1'b0;
         end
      end
   endtask
endmodule // etc_event_src

// ===== sim/etc_timer_properties.sv
// Purpose: Port assertions for the timer block
// Assumes: One clock, reset asynchronous active high
// Notes:   Bound into every etc_timer
`timescale 1ns/10ps
// ==========================================
// Checker
module etc_timer_properties (
   input wire        MCLK,
   input wire        RST,
   input wire        AWVALID,
   input wire        AWREADY,
   input wire        BVALID,
   input wire        BREADY,
   input wire [7:0]  ARADDR,
   input wire        ARVALID,
   input wire        ARREADY,
   input wire [31:0] RDATA,
   input wire [1:0]  RRESP,
   input wire        RVALID,
   input wire        RREADY,
   input wire [2:0]  WAVE_OUT,
   input wire [2:0]  WAVE_OE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence s_rd_take;
      ARVALID && ARREADY;
   endsequence
   sequence s_rd_ctl;
      s_rd_take ##0 (ARADDR[3:0] == 4'hC && ARADDR < 8'h30);
   endsequence
   a_rd_ready_tie: assert property (ARREADY == !RVALID)
      else $error("read ready wrong");
   a_rd_answer: assert property (s_rd_take |=> RVALID)
      else $error("read not answered");
   a_rd_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read answer dropped");
   a_wr_answer: assert property (AWVALID && AWREADY |-> ##[1:3] BVALID)
      else $error("write not answered");
   a_wr_hold: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped");
   a_bad_addr: assert property (s_rd_take ##0 (ARADDR >= 8'h30) |=> RRESP == 2'h2 && RDATA == 32'h0)
      else $error("unmapped read wrong");
   a_ctl_read_zero: assert property (s_rd_ctl |=> RDATA[3:2] == 2'h0)
      else $error("set or clear bit read back");
   a_wave_gated: assert property ((WAVE_OUT & ~WAVE_OE) == 3'h0)
      else $error("wave out while disabled");
endmodule // etc_timer_properties
bind etc_timer etc_timer_properties u_chk (.MCLK(MCLK), .RST(RST), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
   .WAVE_OUT(WAVE_OUT), .WAVE_OE(WAVE_OE));

// ===== sim/etc_timer_tb.sv
// Purpose: Self-checking bench for the timer block
// Assumes: 20 ns clock, AXI4-Lite master tasks
// Notes:   Expected values computed from register settings
`timescale 1ns/10ps
// ==========================================
// Bench
module etc_timer_tb;
   reg         mclk, rst, awv, wv, bry, arv, rry;
   reg  [7:0]  awa, ara;
   reg  [31:0] wd, rdat;
   reg  [1:0]  rrs;
   wire        awr, wrr, bv, arr, rv;
   wire [1:0]  brs, rrs_w;
   wire [31:0] rd_w;
   wire [2:0]  ev, wo, woe, irq;
   wire [5:0]  obs = {wo, irq};
   integer     n_errors, num_checks, nirq, cyc, c, n, d;
   etc_timer u_etc_timer (.MCLK(mclk), .RST(rst), .AWADDR(awa), .AWVALID(awv), .AWREADY(awr),
      .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wrr), .BRESP(brs), .BVALID(bv),
      .BREADY(bry), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr), .RDATA(rd_w), .RRESP(rrs_w),
      .RVALID(rv), .RREADY(rry), .EVENT_IN(ev), .WAVE_OUT(wo), .WAVE_OE(woe), .MATCH_IRQ(irq));
   etc_event_src u_src [2:0] (.pin(ev));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (irq[1] === 1'b1) nirq = nirq + 1;
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   task tmo;
      begin
         n_errors = n_errors + 1;
         end_of_test;
      end
   endtask
   // Edges until observed bit reaches level
   task tw(input integer s, input integer v);
      begin
         cyc = 0;
         do begin
            @(posedge mclk);
            cyc = cyc + 1;
         end while (obs[s] !== v[0] && cyc < 5000);
         if (cyc == 5000) tmo;
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      integer i;
      reg     aw_p, w_p, b_p, ar_p, r_p;
      begin
         aw_p = w;
         w_p = w;
         b_p = w;
         ar_p = !w;
         r_p = !w;
         awa <= a;
         ara <= a;
         wd <= d;
         awv <= w;
         wv <= w;
         bry <= w;
         arv <= !w;
         rry <= !w;
         // Pending flags are blocking: the NBA-driven strobes lag one step
         for (i = 0; i < 50 && (b_p || r_p); i = i + 1) begin
            @(posedge mclk);
            if (aw_p && awr) begin
               aw_p = 1'b0;
               awv <= 1'b0;
            end
            if (w_p && wrr) begin
               w_p = 1'b0;
               wv <= 1'b0;
            end
            if (ar_p && arr) begin
               ar_p = 1'b0;
               arv <= 1'b0;
            end
            if (b_p && bv) begin
               b_p = 1'b0;
               bry <= 1'b0;
            end
            if (r_p && rv) begin
               r_p = 1'b0;
               rdat = rd_w;
               rrs = rrs_w;
               rry <= 1'b0;
            end
         end
         if (i == 50) tmo;
         // Let an edge pass before the next call drives the strobes again
         @(posedge mclk);
      end
   endtask
   initial begin
      n_errors = 0;
      num_checks = 0;
      nirq = 0;
      rst = 1'b1;
      {awv, wv, bry, arv, rry, awa, ara, wd} = 0;
      n = $urandom(49);
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (n = 0; n <= 8'h30; n = n + 4) begin
         bus(0, n, 0);
         chk("reg", 0, rdat);
         chk("resp", (n == 8'h30) ? 2 : 0, rrs);
      end
      $display("test reset done");
      bus(1, 8'h18, 1);
      bus(1, 8'h14, 3);
      bus(1, 8'h1C, 8'h80);
      u_src[1].pulse(2, 47);
      repeat (6) @(posedge mclk);
      bus(0, 8'h10, 0);
      chk("evcount", 2, rdat);
      u_src[1].pulse(2, 400);
      repeat (6) @(posedge mclk);
      bus(0, 8'h10, 0);
      chk("evwrap", 0, rdat);
      chk("evirq", 1, nirq);
      bus(1, 8'h24, 8'hFF);
      bus(1, 8'h2C, 8'h80);
      u_src[2].pulse(3, 47);
      repeat (6) @(posedge mclk);
      bus(0, 8'h20, 0);
      chk("fall", 3, rdat);
      $display("test events done");
      for (c = 2; c < 8; c = c + 1) begin
         n = 1 + $urandom % 3;
         d = 1 << (2 * c - 4);
         bus(1, 8'h0C, 0);
         bus(1, 8'h08, c);
         bus(1, 8'h04, n);
         bus(1, 8'h0C, 8'h8B);
         tw(0, 1);
         tw(0, 1);
         chk("gap", (n + 1) * d, cyc);
      end
      bus(1, 8'h0C, 8'h0B);
      bus(1, 8'h08, 2);
      bus(0, 8'h0C, 0);
      chk("mode", 8'h03, rdat);
      chk("level", 1, wo[0]);
      bus(1, 8'h0C, 8'h83);
      tw(3, 0);
      tw(3, 1);
      chk("half", n + 1, cyc);
      bus(1, 8'h0C, 8'h82);
      repeat (2) @(posedge mclk);
      chk("gated", 0, wo[0]);
      bus(1, 8'h0C, 0);
      bus(0, 8'h00, 0);
      chk("cleared", 0, rdat);
      $display("test square done");
      n = 8 + $urandom % 32;
      bus(1, 8'h2C, 0);
      bus(1, 8'h28, 2);
      bus(1, 8'h24, n);
      bus(1, 8'h2C, 8'hC1);
      chk("pwmoff", 0, wo[2]);
      tw(5, 1);
      tw(5, 0);
      chk("width", n + 1, cyc);
      tw(5, 1);
      chk("idle", 255 - n, cyc);
      bus(1, 8'h2C, 8'h43);
      repeat (2) @(posedge mclk);
      chk("stop", 1, wo[2]);
      $display("test pwm done");
      bus(1, 8'h1C, 0);
      bus(1, 8'h18, 2);
      bus(1, 8'h14, 8'hC8);
      bus(1, 8'h1C, 8'h80);
      repeat (100) @(posedge mclk);
      bus(1, 8'h14, 10);
      tw(1, 1);
      chk("wrap", 1, cyc > 140);
      bus(1, 8'h1C, 0);
      bus(1, 8'h1C, 8'h80);
      tw(1, 1);
      chk("restart", 1, cyc < 13);
      $display("test lower compare done");
      end_of_test;
   end
endmodule // etc_timer_tb
